// ---- rtl/mrc_map.svh ----
`ifndef MRC_MAP_SVH
`define MRC_MAP_SVH
`define MRC_ADDR_LOW_A      8'h76
`define MRC_ADDR_LOW_B      8'h77
`define MRC_ADDR_CFG        8'h78
`define MRC_ADDR_PULSE      8'h7b
`define MRC_ADDR_TEST_ONE   8'h7e
`define MRC_ADDR_TEST_TWO   8'h7f
`define MRC_CFG_RESET       8'h00
`define MRC_PULSE_RESET     8'h55
`define MRC_TEST_RESET      8'h00
`define MRC_LOW_RESET       8'h00
`define MRC_RD_IDLE         8'h00
`define MRC_PEND_ALL        8'hff
`define MRC_PEND_NONE       8'h00
`define MRC_FIELD_W         2
`define MRC_COUNT_W         3
`define MRC_FAN_COUNT       4
`define MRC_COUNT_RESET     12'h492
`define MRC_BIT_ALERT       0
`define MRC_BIT_FAST        3
`define MRC_BIT_CONT_LO     4
`define MRC_SLOW_MS         1000
`define MRC_FAST_MS         250
`define MRC_CLK_KHZ         200000
`endif

// ---- rtl/mrc_pkg.sv ----
package mrc_pkg;
    typedef enum logic [0:0] {
        MRC_LIVE   = 1'b0,
        MRC_FROZEN = 1'b1
    } mrc_snap_t;
endpackage

// ---- rtl/mrc_regs.sv ----
`include "mrc_map.svh"

module mrc_regs
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrite,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regRead,
    output logic      [7:0]  regRdData,
    input  wire logic        configLock,
    input  wire logic [7:0]  highReadDoneA,
    input  wire logic [7:0]  highReadDoneB,
    input  wire logic        convUpdate,
    input  wire logic [7:0]  newLowA,
    input  wire logic [7:0]  newLowB,
    output logic             snapFrozenA,
    output logic             snapFrozenB,
    output logic             alertFunctionSelect,
    output logic             tachMeasureTick,
    output logic      [3:0]  continuousMeasEnable,
    output logic      [11:0] pulsesPerRevFan
);
    // periods counted in cycles of the single system clock
    localparam int SLOW_CYC = `MRC_SLOW_MS * `MRC_CLK_KHZ;
    localparam int FAST_CYC = `MRC_FAST_MS * `MRC_CLK_KHZ;

    logic      [7:0]  lowA;
    logic      [7:0]  lowB;
    logic      [7:0]  pinTachCfg;
    logic      [7:0]  pulseSelect;
    logic      [7:0]  testOne;
    logic      [7:0]  testTwo;
    logic      [7:0]  pendA;
    logic      [7:0]  pendB;
    logic      [27:0] rateCount;
    logic      [27:0] rateLimit;
    logic      [7:0]  next_pulseSelect;
    logic      [11:0] next_pulsesPerRevFan;
    logic      [7:0]  next_regRdData;
    logic             hitLowA;
    logic             hitLowB;
    logic             hitCfg;
    logic             hitPulse;
    logic             hitTestOne;
    logic             hitTestTwo;
    logic             cfgWriteOk;
    logic             pulseWriteOk;
    logic             rateWrap;
    mrc_pkg::mrc_snap_t stateA;
    mrc_pkg::mrc_snap_t stateB;

    // one address decode shared by reads, writes and freezes
    assign hitLowA    = (regAddr == `MRC_ADDR_LOW_A);
    assign hitLowB    = (regAddr == `MRC_ADDR_LOW_B);
    assign hitCfg     = (regAddr == `MRC_ADDR_CFG);
    assign hitPulse   = (regAddr == `MRC_ADDR_PULSE);
    assign hitTestOne = (regAddr == `MRC_ADDR_TEST_ONE);
    assign hitTestTwo = (regAddr == `MRC_ADDR_TEST_TWO);
    // lock gates only the config byte; the pulse byte stays writable
    assign cfgWriteOk   = regWrite && hitCfg && !configLock;
    assign pulseWriteOk = regWrite && hitPulse;

    // freeze A until every high-byte reading it covers is read
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            stateA <= mrc_pkg::MRC_LIVE;
            pendA  <= `MRC_PEND_NONE;
        end
        else
        begin
            case (stateA)
                mrc_pkg::MRC_LIVE:
                begin
                    if (regRead && hitLowA)
                    begin
                        stateA <= mrc_pkg::MRC_FROZEN;
                        pendA  <= `MRC_PEND_ALL;
                    end
                end
                mrc_pkg::MRC_FROZEN:
                begin
                    pendA <= pendA & ~highReadDoneA;
                    if ((pendA & ~highReadDoneA) == `MRC_PEND_NONE)
                    begin
                        stateA <= mrc_pkg::MRC_LIVE;
                    end
                end
                default: stateA <= mrc_pkg::MRC_LIVE;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            stateB <= mrc_pkg::MRC_LIVE;
            pendB  <= `MRC_PEND_NONE;
        end
        else
        begin
            case (stateB)
                mrc_pkg::MRC_LIVE:
                begin
                    if (regRead && hitLowB)
                    begin
                        stateB <= mrc_pkg::MRC_FROZEN;
                        pendB  <= `MRC_PEND_ALL;
                    end
                end
                mrc_pkg::MRC_FROZEN:
                begin
                    pendB <= pendB & ~highReadDoneB;
                    if ((pendB & ~highReadDoneB) == `MRC_PEND_NONE)
                    begin
                        stateB <= mrc_pkg::MRC_LIVE;
                    end
                end
                default: stateB <= mrc_pkg::MRC_LIVE;
            endcase
        end
    end

    assign snapFrozenA = (stateA == mrc_pkg::MRC_FROZEN);
    assign snapFrozenB = (stateB == mrc_pkg::MRC_FROZEN);

    // low bits only track conversions while live
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            lowA <= `MRC_LOW_RESET;
        end
        else if (convUpdate && !snapFrozenA)
        begin
            lowA <= newLowA;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            lowB <= `MRC_LOW_RESET;
        end
        else if (convUpdate && !snapFrozenB)
        begin
            lowB <= newLowB;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pinTachCfg <= `MRC_CFG_RESET;
        end
        else if (cfgWriteOk)
        begin
            pinTachCfg <= regWrData;
        end
    end

    // count output loads with its byte, so both change on one edge
    always_comb
    begin
        next_pulseSelect = pulseSelect;
        if (pulseWriteOk)
        begin
            next_pulseSelect = regWrData;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pulseSelect     <= `MRC_PULSE_RESET;
            pulsesPerRevFan <= `MRC_COUNT_RESET;
        end
        else
        begin
            pulseSelect     <= next_pulseSelect;
            pulsesPerRevFan <= next_pulsesPerRevFan;
        end
    end

    // test registers ignore host writes, locked or not
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            testOne <= `MRC_TEST_RESET;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            testTwo <= `MRC_TEST_RESET;
        end
    end

    // pin mux sits outside; the alert select and the four continuous enables leave this block
    assign alertFunctionSelect = pinTachCfg[`MRC_BIT_ALERT];
    assign continuousMeasEnable =
        pinTachCfg[`MRC_BIT_CONT_LO +: 4];

    // field code n means n+1 pulses; two code bits, three count bits per fan
    genvar f;
    generate
        for (f = 0; f < `MRC_FAN_COUNT; f++)
        begin : g_pulse
            assign next_pulsesPerRevFan[`MRC_COUNT_W*f +: `MRC_COUNT_W] =
                {1'b0, next_pulseSelect[`MRC_FIELD_W*f +: `MRC_FIELD_W]}
                + 3'h1;
        end
    endgenerate

    // the fast bit picks the shorter period for every fan channel
    always_comb
    begin
        if (pinTachCfg[`MRC_BIT_FAST])
        begin
            rateLimit = 28'(FAST_CYC - 1);
        end
        else
        begin
            rateLimit = 28'(SLOW_CYC - 1);
        end
    end

    assign rateWrap = (rateCount >= rateLimit);

    // free-running: a rate change applies at once, at the next cycle's compare
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rateCount <= '0;
        end
        else if (rateWrap)
        begin
            rateCount <= '0;
        end
        else
        begin
            rateCount <= rateCount + 28'h0000001;
        end
    end

    assign tachMeasureTick = rateWrap;

    // unmapped addresses read back as zero
    always_comb
    begin
        next_regRdData = `MRC_RD_IDLE;
        if (hitLowA)
            next_regRdData = lowA;
        else if (hitLowB)
            next_regRdData = lowB;
        else if (hitCfg)
            next_regRdData = pinTachCfg;
        else if (hitPulse)
            next_regRdData = pulseSelect;
        else if (hitTestOne)
            next_regRdData = testOne;
        else if (hitTestTwo)
            next_regRdData = testTwo;
    end

    // read data stands until the next read strobe
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            regRdData <= `MRC_RD_IDLE;
        end
        else if (regRead)
        begin
            regRdData <= next_regRdData;
        end
    end
endmodule

// ---- bench/mrc_regs_monitor.sv ----
module mrc_regs_monitor
(
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  regAddr,
    input wire logic        regWrite,
    input wire logic [7:0]  regWrData,
    input wire logic        regRead,
    input wire logic [7:0]  regRdData,
    input wire logic        configLock,
    input wire logic [7:0]  highReadDoneA,
    input wire logic        snapFrozenA,
    input wire logic        snapFrozenB,
    input wire logic        alertFunctionSelect,
    input wire logic [3:0]  continuousMeasEnable,
    input wire logic [11:0] pulsesPerRevFan
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence cfgWr;
        regWrite && regAddr == 8'h78;
    endsequence
    cfg_alert_a: assert property (
        cfgWr and !configLock |=> alertFunctionSelect == $past(regWrData[0]))
        else $error("alert select not written");
    cfg_cont_a: assert property (
        cfgWr and !configLock
        |=> continuousMeasEnable == $past(regWrData[7:4]))
        else $error("continuous enables not written");
    cfg_lock_a: assert property (
        cfgWr and configLock |=> $stable(continuousMeasEnable))
        else $error("locked config changed");
    freeze_a_a: assert property (
        regRead && regAddr == 8'h76 |=> snapFrozenA)
        else $error("read A did not freeze");
    freeze_b_a: assert property (
        regRead && regAddr == 8'h77 |=> snapFrozenB)
        else $error("read B did not freeze");
    resume_a_a: assert property (
        snapFrozenA && &highReadDoneA && !regRead |=> !snapFrozenA)
        else $error("freeze not released");
    pulse_fan_a: assert property (
        regWrite && regAddr == 8'h7b
        |=> pulsesPerRevFan[2:0] == {1'b0, $past(regWrData[1:0])} + 3'h1)
        else $error("fan one pulse count wrong");
    test_read_a: assert property (
        regRead && regAddr[7:1] == 7'h3f |=> regRdData == 8'h00)
        else $error("test register not zero");
endmodule
bind mrc_regs mrc_regs_monitor u_mon (.*);

// ---- bench/mrc_host_model.sv ----
module mrc_host_model
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] regRdData,
    output logic      [7:0] regAddr,
    output logic            regWrite,
    output logic      [7:0] regWrData,
    output logic            regRead,
    output logic            configLock,
    output logic      [7:0] highReadDoneA,
    output logic      [7:0] highReadDoneB,
    output logic            convUpdate,
    output logic      [7:0] newLowA,
    output logic      [7:0] newLowB
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        {regAddr, regWrite, regWrData, regRead, configLock} = '0;
        {highReadDoneA, highReadDoneB, convUpdate, newLowA, newLowB} = '0;
    end
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        {regWrite, regAddr, regWrData} <= {1'b1, a, d};
        @(posedge ref_clk);
        regWrite <= 1'b0;
        #1;
    endtask
    task automatic r(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        {regRead, regAddr} <= {1'b1, a};
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 d = regRdData;
    endtask
    task automatic cv(input logic [7:0] a, input logic [7:0] b);
        @(posedge ref_clk);
        {convUpdate, newLowA, newLowB} <= {1'b1, a, b};
        @(posedge ref_clk);
        convUpdate <= 1'b0;
    endtask
    task automatic dn(input logic [7:0] v);
        @(posedge ref_clk);
        {highReadDoneA, highReadDoneB} <= {v, v};
    endtask
    task automatic lk;
        @(posedge ref_clk);
        configLock <= 1'b1;
    endtask
endmodule

// ---- bench/tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 0, rst_n = 0, regWrite, regRead, configLock, convUpdate;
    logic snapFrozenA, snapFrozenB, alertFunctionSelect, tachMeasureTick;
    logic [7:0] regAddr, regWrData, regRdData, newLowA, newLowB, d;
    logic [7:0] highReadDoneA, highReadDoneB;
    logic [3:0] continuousMeasEnable;
    logic [11:0] pulsesPerRevFan;
    int fail_count = 0, cmp_count = 0, cyc = 0;
    logic [7:0] ad [5] = '{8'h78, 8'h7b, 8'h7e, 8'h7f, 8'h10};
    logic [7:0] ex [5] = '{8'h00, 8'h55, 8'h00, 8'h00, 8'h00};
    mrc_regs DUT (.*);
    mrc_host_model h (.*);
    always #2.5 ref_clk = ~ref_clk;
    task automatic chk(input string n, input logic [11:0] s, e);
        cmp_count++;
        if (s !== e)
        begin
            fail_count++;
            $display("ERROR %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            fail_count++;
            stop_test;
        end
    end
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            h.r(ad[i], d);
            chk("reset", d, ex[i]);
        end
        chk("count", pulsesPerRevFan, 12'h492);
        chk("tick", tachMeasureTick, 1'b0);
        h.w(8'h78, 8'ha5);
        h.r(8'h78, d);
        chk("cfg", d, 8'ha5);
        chk("alert", alertFunctionSelect, 1'b1);
        chk("cont", continuousMeasEnable, 4'ha);
        h.w(8'h7b, 8'he4);
        chk("pulses", pulsesPerRevFan, 12'h8d1);
        h.w(8'h7e, 8'hff);
        h.r(8'h7e, d);
        chk("test", d, 8'h00);
        h.lk;
        h.w(8'h78, 8'h00);
        h.w(8'h7f, 8'h5a);
        h.r(8'h78, d);
        chk("lock", d, 8'ha5);
        h.r(8'h7f, d);
        chk("locktest", d, 8'h00);
        h.cv(8'h3c, 8'hc3);
        h.r(8'h76, d);
        chk("lowa", d, 8'h3c);
        chk("frozen", snapFrozenA, 1'b1);
        h.r(8'h77, d);
        chk("lowb", d, 8'hc3);
        chk("frozenb", snapFrozenB, 1'b1);
        h.cv(8'h11, 8'h22);
        h.r(8'h76, d);
        chk("held", d, 8'h3c);
        h.dn(8'hff);
        h.dn(8'h00);
        h.cv(8'h11, 8'h22);
        h.r(8'h77, d);
        chk("resume", d, 8'h22);
        chk("freed", snapFrozenA, 1'b0);
        stop_test;
    end
endmodule
